//--- hdl/pspc_pkg.sv
// Purpose: Constants and types for the PLL serial program front end
// Assumes: LSB-first serial stream with zero stuffing after three ones
// Notes: Bit positions index the 8-bit control and 22-bit word
// How it works
// R01 - Bits 011110 form a marker between control data and word data
// R02 - The marker is found by its run of four ones
// R03 - Host stuffs one zero after every three ones outside markers
// R04 - A zero after three ones is dropped, never kept as data
// R05 - Every word travels least significant bit first, one bit per clock
// R06 - Data is sampled on each rising serial clock edge
// R07 - On a marker the eight bits before it become control at once
// R08 - Control starts at 0000 0100: reference out, loading off
// R09 - Bits 7, 6, 4 reserved zero; bit 5 shortens duty cycle
// R10 - Bit 3 picks pin role: output enable or reference bypass
// R11 - Bit 2 picks source: zero VCO clock, one reference clock
// R12 - Source changes break before make, so the output never glitches
// R13 - Bit 1 set floats the clock output
// R14 - Bit 0 gates word loading; cleared leaves the word intact
// R15 - Word holds P code, duty trim, divider, Q code, range index
// R16 - VCO runs at 2 x ref x P / Q; P = code+3, Q = code+2
// R17 - Divider select divides the VCO clock by two to its power
// R18 - Word duty-trim bit lengthens the output duty cycle
// R19 - Only the top range index bit matters
// R20 - Host keeps the VCO between 50 and 150 MHz
// R21 - Host keeps Q in 3..129, P in 4..130, ref/Q in range
// R22 - Host enables bypass and loading, marker, then the stuffed word
// R23 - Control clearing load with bypass still on commits the word
// R24 - Host waits 10 ms settling, then clears bypass
// R25 - As output enable, pin high drives and pin low floats
// R26 - Recent destuffed bits are kept to find the bits before a marker
// R27 - Output floats on bit 1 or on a low output-enable pin
package pspc_pkg;
    // ****************************************************
    // Layouts and reset values
    // ****************************************************
    localparam int CTRL_W = 8;
    localparam int FREQ_W = 22;
    localparam int HIST_W = 34;
    localparam int PAY_LSB = 22;
    localparam int CB_LOAD = 0;
    localparam int CB_TRI = 1;
    localparam int CB_REF = 2;
    localparam int CB_PIN = 3;
    localparam int CB_DUTY = 5;
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam logic [21:0] FREQ_RESET = 22'h000000;
    localparam int F_RANGE_MSB = 3;
    localparam int F_Q_LSB = 4;
    localparam int F_DIV_LSB = 11;
    localparam int F_DUTY = 14;
    localparam int F_P_LSB = 15;
    localparam logic [7:0] P_OFFSET = 8'h03;
    localparam logic [7:0] Q_OFFSET = 8'h02;
    localparam logic [1:0] RUN_FULL = 2'h3;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_NS = 5;
    localparam int GAP_NS = 20;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] GAP_LOAD = 3'(GAP_CYC - 1);
    typedef enum logic [1:0] {SRC_REF, SRC_BREAK, SRC_VCO} pspc_src_e;
    // ****************************************************
    // State records
    // ****************************************************
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic [1:0] ones;
        logic [HIST_W-1:0] hist;
        logic en;
        logic [CTRL_W-1:0] ev_ctrl;
        logic [FREQ_W-1:0] ev_freq;
        logic ev_commit;
        logic ev_tog;
    } pspc_lnk_s;
    typedef struct packed {
        logic tog_meta;
        logic tog_sync;
        logic tog_seen;
        logic pin_meta;
        logic pin_sync;
        logic [CTRL_W-1:0] ctrl;
        logic [FREQ_W-1:0] freq;
        pspc_src_e st;
        logic to_vco;
        logic [2:0] gap;
        logic ref_en;
        logic vco_en;
        logic oe;
        logic [7:0] p_val;
        logic [7:0] q_val;
        logic [7:0] div_ratio;
    } pspc_sys_s;
endpackage

//--- hdl/pspc_top.sv
// Purpose: Serial programming front end of a PLL clock synthesizer
// Assumes: Serial clock is a separate domain; data valid at its rise
// Notes: Analog PLL is outside; this block drives its settings
`timescale 1ns/10ps
module pspc_top (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic multipurpose_pin_in,
    output logic synth_output_oe_out,
    output logic src_ref_en_out,
    output logic src_vco_en_out,
    output logic [7:0] output_control_out,
    output logic [21:0] frequency_word_out,
    output logic [7:0] p_value_out,
    output logic [7:0] q_value_out,
    output logic [7:0] div_ratio_out,
    output logic duty_short_out,
    output logic duty_long_out,
    output logic range_high_out,
    output logic load_enable_out
);

    // ****************************************************
    // State
    // ****************************************************
    pspc_pkg::pspc_lnk_s lnk_reg;
    pspc_pkg::pspc_lnk_s lnk_next;
    pspc_pkg::pspc_sys_s sys_reg;
    pspc_pkg::pspc_sys_s sys_next;
    logic [pspc_pkg::CTRL_W-1:0] payload;
    logic marker_hit;
    logic stuff_hit;
    logic ctrl_event;
    logic want_ref;

    // ****************************************************
    // Serial clock domain
    // ****************************************************

    // Marker is the fourth one in a row
    assign marker_hit = serial_data_in && (lnk_reg.ones == pspc_pkg::RUN_FULL); // R02
    // Zero after three ones is a stuffed bit
    assign stuff_hit = !serial_data_in && (lnk_reg.ones == pspc_pkg::RUN_FULL); // R04
    // Eight destuffed bits ahead of the marker's leading zero
    assign payload = lnk_reg.hist[pspc_pkg::PAY_LSB +: pspc_pkg::CTRL_W]; // R07

    // Next state of the link logic
    always_comb begin
        lnk_next = lnk_reg;
        lnk_next.rst_meta = sys_rst_in;
        lnk_next.rst_sync = lnk_reg.rst_meta;
        if (lnk_reg.rst_sync) begin
            lnk_next.ones = 2'h0;
            lnk_next.hist = '0;
            lnk_next.en = pspc_pkg::CTRL_RESET[pspc_pkg::CB_LOAD];
            lnk_next.ev_ctrl = pspc_pkg::CTRL_RESET;
            lnk_next.ev_freq = pspc_pkg::FREQ_RESET;
            lnk_next.ev_commit = 1'b0;
            lnk_next.ev_tog = 1'b0;
        end else if (marker_hit) begin
            // Publish the new control byte and flip the event toggle
            lnk_next.ones = 2'h0; // R01
            lnk_next.ev_ctrl = payload; // R07
            lnk_next.ev_freq = lnk_reg.hist[pspc_pkg::FREQ_W-1:0]; // R15
            // Commit only on a load-enable fall with bypass still on
            lnk_next.ev_commit = lnk_reg.en && !payload[pspc_pkg::CB_LOAD]
                && payload[pspc_pkg::CB_REF]; // R22 R23
            lnk_next.en = payload[pspc_pkg::CB_LOAD]; // R14
            lnk_next.ev_tog = !lnk_reg.ev_tog;
        end else if (stuff_hit) begin
            lnk_next.ones = 2'h0; // R04
        end else begin
            // Newest bit enters at the top, so the first bit ends lowest
            lnk_next.hist = {serial_data_in, lnk_reg.hist[pspc_pkg::HIST_W-1:1]}; // R05 R26
            if (serial_data_in) begin
                lnk_next.ones = lnk_reg.ones + 2'h1;
            end else begin
                lnk_next.ones = 2'h0;
            end
        end
    end

    // Link registers; reset arrives through its own two-stage sync
    always_ff @(posedge serial_clk_in) begin
        lnk_reg <= lnk_next; // R06
    end

    // ****************************************************
    // System clock domain
    // ****************************************************

    // New control byte seen once the toggle has crossed
    assign ctrl_event = sys_reg.tog_sync ^ sys_reg.tog_seen;
    // Pin as bypass select forces the reference as well
    assign want_ref = sys_reg.ctrl[pspc_pkg::CB_REF]
        || (sys_reg.ctrl[pspc_pkg::CB_PIN] && sys_reg.pin_sync); // R10 R11

    // Next state of the system logic
    always_comb begin
        sys_next = sys_reg;
        sys_next.tog_meta = lnk_reg.ev_tog;
        sys_next.tog_sync = sys_reg.tog_meta;
        sys_next.tog_seen = sys_reg.tog_sync;
        sys_next.pin_meta = multipurpose_pin_in;
        sys_next.pin_sync = sys_reg.pin_meta;
        // Link words stay put for several serial clocks after the toggle
        if (ctrl_event) begin
            sys_next.ctrl = lnk_reg.ev_ctrl; // R07
            if (lnk_reg.ev_commit) begin
                sys_next.freq = lnk_reg.ev_freq; // R23
            end
        end
        // Float on bit 1, or on a low pin while it acts as enable
        sys_next.oe = !sys_reg.ctrl[pspc_pkg::CB_TRI]
            && (sys_reg.ctrl[pspc_pkg::CB_PIN] || sys_reg.pin_sync); // R13 R25 R27
        // Settings handed to the analog loop, codes turned to counts
        sys_next.p_val = 8'(sys_reg.freq[pspc_pkg::F_P_LSB +: 7]) + pspc_pkg::P_OFFSET; // R16
        sys_next.q_val = 8'(sys_reg.freq[pspc_pkg::F_Q_LSB +: 7]) + pspc_pkg::Q_OFFSET; // R16
        sys_next.div_ratio = 8'h01 << sys_reg.freq[pspc_pkg::F_DIV_LSB +: 3]; // R17
        // Break before make: both sources off for a gap on every switch
        unique case (sys_reg.st)
            pspc_pkg::SRC_REF: begin
                if (!want_ref) begin
                    sys_next.st = pspc_pkg::SRC_BREAK; // R12
                    sys_next.to_vco = 1'b1;
                    sys_next.gap = pspc_pkg::GAP_LOAD;
                    sys_next.ref_en = 1'b0;
                end
            end
            pspc_pkg::SRC_VCO: begin
                if (want_ref) begin
                    sys_next.st = pspc_pkg::SRC_BREAK; // R12
                    sys_next.to_vco = 1'b0;
                    sys_next.gap = pspc_pkg::GAP_LOAD;
                    sys_next.vco_en = 1'b0;
                end
            end
            pspc_pkg::SRC_BREAK: begin
                // A request flip during the gap waits for the next pass
                if (sys_reg.gap == 3'h0) begin
                    if (sys_reg.to_vco) begin
                        sys_next.st = pspc_pkg::SRC_VCO;
                        sys_next.vco_en = 1'b1;
                    end else begin
                        sys_next.st = pspc_pkg::SRC_REF;
                        sys_next.ref_en = 1'b1;
                    end
                end else begin
                    sys_next.gap = sys_reg.gap - 3'h1;
                end
            end
            default: begin
                sys_next.st = pspc_pkg::SRC_BREAK;
                sys_next.to_vco = 1'b0;
                sys_next.gap = pspc_pkg::GAP_LOAD;
                sys_next.ref_en = 1'b0;
                sys_next.vco_en = 1'b0;
            end
        endcase
    end

    // System registers with power-up values
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            sys_reg <= '0;
            sys_reg.ctrl <= pspc_pkg::CTRL_RESET; // R08
            sys_reg.freq <= pspc_pkg::FREQ_RESET;
            sys_reg.st <= pspc_pkg::SRC_REF;
            sys_reg.ref_en <= 1'b1;
            sys_reg.p_val <= pspc_pkg::P_OFFSET;
            sys_reg.q_val <= pspc_pkg::Q_OFFSET;
            sys_reg.div_ratio <= 8'h01;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************

    // All straight from flops
    assign synth_output_oe_out = sys_reg.oe;
    assign src_ref_en_out = sys_reg.ref_en;
    assign src_vco_en_out = sys_reg.vco_en;
    assign output_control_out = sys_reg.ctrl;
    assign frequency_word_out = sys_reg.freq;
    assign p_value_out = sys_reg.p_val;
    assign q_value_out = sys_reg.q_val;
    assign div_ratio_out = sys_reg.div_ratio;
    // Duty trims are analog knobs; reserved bits are passed, not acted on
    assign duty_short_out = sys_reg.ctrl[pspc_pkg::CB_DUTY]; // R09
    assign duty_long_out = sys_reg.freq[pspc_pkg::F_DUTY]; // R18
    // Lower index bits carry no meaning
    assign range_high_out = sys_reg.freq[pspc_pkg::F_RANGE_MSB]; // R19
    assign load_enable_out = sys_reg.ctrl[pspc_pkg::CB_LOAD];

    // ****************************************************
    // Checks, system domain
    // ****************************************************

    // Never both sources at once
    a_break_make: assert property ( // R12
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !(src_ref_en_out && src_vco_en_out))
        else $error("both clock sources enabled");

    // Gap of four idle cycles before the VCO takes over
    a_gap_length: assert property ( // R12
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $fell(src_ref_en_out) |-> !src_vco_en_out [*4] ##1 src_vco_en_out)
        else $error("switch gap length wrong");

    // Three-state bit floats the output
    a_tri_floats: assert property ( // R13
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        sys_reg.ctrl[pspc_pkg::CB_TRI] |=> !synth_output_oe_out)
        else $error("output driven while three-stated");

    // Low enable pin floats the output
    a_pin_floats: assert property ( // R25
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (!sys_reg.ctrl[pspc_pkg::CB_PIN] && !sys_reg.pin_sync)
        |=> !synth_output_oe_out)
        else $error("output driven with enable pin low");

    // High enable pin drives the output
    a_pin_drives: assert property ( // R25
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (!sys_reg.ctrl[pspc_pkg::CB_TRI] && !sys_reg.ctrl[pspc_pkg::CB_PIN]
        && sys_reg.pin_sync) |=> synth_output_oe_out)
        else $error("output floats with enable pin high");

    // Control byte taken on each marker event
    a_ctrl_taken: assert property ( // R07
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        ctrl_event |=> output_control_out == $past(lnk_reg.ev_ctrl))
        else $error("control byte not taken");

    // Word untouched without a commit
    a_word_kept: assert property ( // R14
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !(ctrl_event && lnk_reg.ev_commit) |=> $stable(frequency_word_out))
        else $error("word changed without commit");

    // Word loaded on a commit
    a_word_commit: assert property ( // R23
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ctrl_event && lnk_reg.ev_commit)
        |=> frequency_word_out == $past(lnk_reg.ev_freq))
        else $error("word not committed");

    // P count is the code plus three
    a_p_count: assert property ( // R16
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $stable(frequency_word_out) |->
        p_value_out == 8'(frequency_word_out[21:15]) + 8'h03)
        else $error("P count wrong");

    // Q count is the code plus two, one cycle behind a steady word
    a_q_count: assert property ( // R16
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $stable(frequency_word_out) |->
        q_value_out == 8'(frequency_word_out[10:4]) + 8'h02)
        else $error("Q count wrong");

    // Divide ratio is a power of two of the select
    a_div_ratio: assert property ( // R17
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $stable(frequency_word_out) |->
        div_ratio_out == (8'h01 << frequency_word_out[13:11]))
        else $error("divide ratio wrong");

    // ****************************************************
    // Checks, serial domain
    // ****************************************************

    // Stuffed zero leaves the history alone
    a_stuff_drop: assert property ( // R04
        @(posedge serial_clk_in) disable iff (lnk_reg.rst_sync)
        (lnk_reg.ones == 2'h3 && !serial_data_in) |=> $stable(lnk_reg.hist))
        else $error("stuffed zero kept as data");

    // Fourth one raises a control event
    a_marker_event: assert property ( // R02
        @(posedge serial_clk_in) disable iff (lnk_reg.rst_sync)
        (lnk_reg.ones == 2'h3 && serial_data_in) |=> $changed(lnk_reg.ev_tog))
        else $error("marker missed");

    // Plain data bits enter at the top of the history
    a_bit_shift: assert property ( // R05
        @(posedge serial_clk_in) disable iff (lnk_reg.rst_sync)
        (lnk_reg.ones != 2'h3)
        |=> lnk_reg.hist[33] == $past(serial_data_in))
        else $error("data bit not shifted");

endmodule

//--- verification/pspc_host_model.sv
// Purpose: Host side of the serial link: shift clock, data, stuffing
// Assumes: Data changes while the clock is low; 64 ns bit period
// Notes: Clock stands still between frames; data shows inverse when idle
`timescale 1ns/10ps
module pspc_host_model (
    output logic serial_clk_out,
    output logic serial_data_out
);
    // ****************************************
    // Bit level
    // ****************************************
    int ones_run;

    initial begin
        serial_clk_out = 1'b0;
        serial_data_out = 1'b0;
        ones_run = 0;
    end

    // Data set in the low half, taken at the rise
    task automatic put_bit(input logic b);
        serial_data_out = b;
        #32;
        serial_clk_out = 1'b1;
        #32;
        serial_clk_out = 1'b0;
    endtask

    // Zeros only, used around reset; line released afterwards
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) put_bit(1'b0);
        ones_run = 0;
        serial_data_out = 1'b1;
    endtask

    // Payload, low bit first; run count spans words within a frame
    task automatic send_data(input logic [21:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            put_bit(v[i]);
            ones_run = v[i] ? ones_run + 1 : 0;
            if (ones_run == 3) begin
                put_bit(1'b0);
                ones_run = 0;
            end
        end
    endtask

    // Control byte then the unstuffed marker 0,1,1,1,1,0
    task automatic send_ctrl(input logic [7:0] c);
        logic [5:0] mark;
        mark = 6'h1e;
        send_data({14'h0000, c}, 8);
        for (int i = 0; i < 6; i++) put_bit(mark[i]);
        ones_run = 0;
        serial_data_out = ~serial_data_out; // Frame over, old value not held
    endtask
endmodule

//--- verification/pll_serial_program_ctrl_bench.sv
// Purpose: Self-checking bench for the serial PLL program front end
// Assumes: Host model owns the serial pins; bench drives pin and reset
// Notes: Expectations come from field layouts, never from outputs
`timescale 1ns/10ps
module pll_serial_program_ctrl_bench;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk_sys_in, sys_rst_in, pin, sclk, sdata;
    logic oe, ref_en, vco_en, dshort, dlong, rhigh, load;
    logic [7:0] ctrl, p_val, q_val, div;
    logic [21:0] word;
    int error_cnt, checked;
    int cyc = 0;

    pspc_host_model host (.serial_clk_out(sclk), .serial_data_out(sdata));

    pspc_top dut (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .serial_clk_in(sclk), .serial_data_in(sdata),
        .multipurpose_pin_in(pin), .synth_output_oe_out(oe),
        .src_ref_en_out(ref_en), .src_vco_en_out(vco_en),
        .output_control_out(ctrl), .frequency_word_out(word),
        .p_value_out(p_val), .q_value_out(q_val), .div_ratio_out(div),
        .duty_short_out(dshort), .duty_long_out(dlong),
        .range_high_out(rhigh), .load_enable_out(load)
    );

    // 200 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic chk_vec(input string what, input logic [21:0] exp, input logic [21:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard: whole run is far below this
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            complete_run();
        end
    end

    // Both sources gated at once would glitch the output
    always @(negedge clk_sys_in) begin
        if (cyc > 2 && !sys_rst_in) chk_bit("src_overlap", 1'b0, ref_en & vco_en);
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic settle();
        repeat (16) @(negedge clk_sys_in);
    endtask

    // Reset spans several serial edges so the link side clears too
    task automatic do_reset();
        sys_rst_in = 1'b1;
        host.idle_clocks(4);
        @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        host.idle_clocks(3);
        settle();
    endtask

    task automatic prog(input logic [21:0] w);
        host.send_ctrl(8'h25);
        chk_bit("load_en", 1'b1, load);
        host.send_data(w, 22);
        host.send_ctrl(8'h24);
        settle();
    endtask

    task automatic chk_word(input logic [21:0] w);
        chk_vec("word", w, word);
        chk_vec("p_value", {1'b0, w[21:15]} + 8'h03, p_val);
        chk_vec("q_value", {1'b0, w[10:4]} + 8'h02, q_val);
        chk_vec("div_ratio", 22'h000001 << w[13:11], div);
        chk_bit("duty_long", w[14], dlong);
        chk_bit("range_high", w[3], rhigh);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk_vec("control", 8'h04, ctrl);
        chk_word(22'h000000);
        chk_bit("ref_en", 1'b1, ref_en);
        chk_bit("vco_en", 1'b0, vco_en);
        chk_bit("load_en", 1'b0, load);
        chk_bit("oe", 1'b1, oe);
        $display("test reset done");
    endtask

    // Byte with three ones in a row needs a stuffed zero inside the control data
    task automatic t_control();
        host.send_ctrl(8'h2e);
        settle();
        chk_vec("control", 8'h2e, ctrl);
        chk_bit("duty_short", 1'b1, dshort);
        chk_bit("oe", 1'b0, oe);
        host.send_ctrl(8'h04);
        settle();
        chk_bit("oe", 1'b1, oe);
        chk_bit("duty_short", 1'b0, dshort);
        $display("test control done");
    endtask

    // P=91 Q=33 divide by 2; then a word sent while loading is off
    task automatic t_program();
        prog(22'h2c49f0);
        chk_word(22'h2c49f0);
        host.send_data(22'h155555, 22);
        host.send_ctrl(8'h24);
        settle();
        chk_vec("word_kept", 22'h2c49f0, word);
        $display("test program done");
    endtask

    // Every divider code, Q at both ends of its range, P at its top end only, both range indices
    task automatic t_divider();
        logic [21:0] w;
        for (int m = 0; m < 8; m++) begin
            w = {7'h7f - 7'(m), 1'b0, 3'(m), 7'(m * 18 + 1), m[0], 3'h0};
            prog(w);
            chk_word(w);
        end
        $display("test divider done");
    endtask

    // Break before make, then the pin as bypass select and as enable
    task automatic t_switch();
        int n;
        int gap;
        n = 0;
        gap = 0;
        // Settling wait left out: no VCO stands behind this model
        fork
            host.send_ctrl(8'h20);
            begin
                while (ref_en !== 1'b0 && n < 400) begin
                    @(negedge clk_sys_in);
                    n++;
                end
                while (vco_en !== 1'b1 && gap < 32) begin
                    @(negedge clk_sys_in);
                    gap++;
                end
            end
        join
        chk_vec("gap_cycles", 22'(pspc_pkg::GAP_CYC), 22'(gap));
        chk_bit("vco_en", 1'b1, vco_en);
        host.send_ctrl(8'h28);
        settle();
        settle();
        chk_bit("ref_en", 1'b1, ref_en);
        chk_bit("oe", 1'b1, oe);
        pin = 1'b0;
        settle();
        chk_bit("vco_en", 1'b1, vco_en);
        chk_bit("oe", 1'b1, oe);
        host.send_ctrl(8'h20);
        settle();
        chk_bit("oe", 1'b0, oe);
        pin = 1'b1;
        settle();
        chk_bit("oe", 1'b1, oe);
        $display("test switch done");
    endtask

    // Reset in mid-run from the VCO source must restore power-up state
    task automatic t_rerun();
        do_reset();
        t_reset();
        $display("test rerun done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        pin = 1'b1;
        error_cnt = 0;
        checked = 0;
        do_reset();
        t_reset();
        t_control();
        t_program();
        t_divider();
        t_switch();
        t_rerun();
        complete_run();
    end
endmodule
